// ---- config_bitstream_loader.sv ----
/*
  configuration loading front end: master serial, master parallel and
  peripheral modes, with forwarding of header and overflow bits to a
  downstream chain on the serial output.
  assumes REF_CLK is the 100 MHz timing generator clock, BUS_CLK is the
  processor bus clock, and every other input is an asynchronous pin.
*/
// What this block does
// - sample serial input on the following rise
// - forward header and overflow, 1.5 periods late
// - low-during-config output stays high after configuration
// - early done option raises done with the last own bit
// - drive address, latch byte before stepping address
// - serialise bytes LSB first, D0 1.5 later
// - parallel clock runs eight times address rate
// - tolerate memory access beyond 4000 ns
// - capture bus byte on trailing write edge
// - double buffer bytes into serial shift path
// - eight configuration clocks per accepted write
// - busy on receipt, ready after buffer transfer
// - busy lasts between 2.5 and 9 periods
// - new byte waits for shifter and generator phase
// - last byte: seven bits, clock parked high
// - reset pin low holds off configuration start
module config_bitstream_loader #(
  parameter int CFG_DIV = cfg_loader_pkg::CFG_DIV,
  parameter int PREAMBLE_BITS = cfg_loader_pkg::PREAMBLE_BITS,
  parameter int OWN_BITS = cfg_loader_pkg::OWN_BITS,
  parameter int ADDR_W = cfg_loader_pkg::ADDR_W
) (
  input wire logic REF_CLK,
  input wire logic ARST_N,
  input wire logic BUS_CLK,
  input wire logic CFG_RESET_N,
  input wire logic [1:0] MODE,
  input wire logic EARLY_DONE,
  input wire logic ADDR_DOWN,
  input wire logic SER_DIN,
  input wire logic [7:0] DATA_IN,
  input wire logic CHIP_SEL_A_N,
  input wire logic CHIP_SEL_B_N,
  input wire logic CHIP_SEL_C,
  input wire logic WRITE_STROBE_N,
  output logic CFG_CLK,
  output logic DOUT,
  output logic [ADDR_W-1:0] ADDR,
  output logic READY_BUSY,
  output logic LOW_DURING_CFG,
  output logic DONE,
  output logic CORE_BIT,
  output logic CORE_BIT_STB
);
  localparam int HALF = CFG_DIV / 2; // phase of the falling edge
  localparam int PH_W = $clog2(CFG_DIV);
  // shortest busy time: two and a half configuration clock periods
  localparam int BUSY_MIN = (5 * CFG_DIV) / 2;
  localparam int BM_W = $clog2(BUSY_MIN + 1);
  localparam int CNT_W = 24; // stream bit counter width
  localparam int OWN_END = PREAMBLE_BITS + OWN_BITS;
  // time from address change to byte sample, in nanoseconds
  localparam int ACCESS_NS = cfg_loader_pkg::BURST_LEN * CFG_DIV *
                             cfg_loader_pkg::REF_PERIOD_NS;

  // refuse settings the logic cannot serve
  if (CFG_DIV < 4 || (CFG_DIV % 2) != 0) begin : g_bad_div
    $error("CFG_DIV must be even and at least 4");
  end
  // slow memories need the whole byte period to settle
  if (ACCESS_NS <= cfg_loader_pkg::MEM_ACCESS_NS) begin : g_bad_access
    $error("byte period too short for the memory access time");
  end
  if (OWN_END >= (1 << CNT_W) || ADDR_W > 16 || ADDR_W < 1) begin : g_bad_w
    $error("stream length or address width out of range");
  end

  typedef enum logic [1:0] {ST_IDLE, ST_LOAD} state_t;

  typedef struct packed {
    logic rst_s1; // first sync stage of the reset pin
    logic rst_s2;
    logic [1:0] mode_s1; // mode pins
    logic [1:0] mode_s2;
    logic early_s1; // early done strap
    logic early_s2;
    logic down_s1; // address direction strap
    logic down_s2;
    logic din_s1; // serial data pin
    logic din_s2;
    logic [7:0] dat_s1; // byte-wide memory data pins
    logic [7:0] dat_s2;
    logic tog_s1; // handover toggle from the bus domain
    logic tog_s2;
    logic tog_s3;
    state_t state; // idle or loading
    logic [1:0] mode; // mode caught at start
    logic early; // early done caught at start
    logic down; // address direction caught at start
    logic [PH_W-1:0] phase; // free-running timing generator
    logic cfg_clk; // configuration clock output
    logic d1; // bit taken at the last rise
    logic f1; // that bit is to be forwarded
    logic d2; // bit taken one rise earlier
    logic f2;
    logic dout; // serial output
    logic [ADDR_W-1:0] addr; // memory address
    logic [2:0] bit_idx; // bit of the parallel byte being sent
    logic [7:0] pbyte; // latched parallel byte
    logic [7:0] buf_byte; // first-level peripheral buffer
    logic buf_full;
    logic [7:0] shift; // second-level peripheral shifter
    logic [3:0] left; // bits still to send from the shifter
    logic parked; // clock held high waiting for a byte
    logic [CNT_W-1:0] bit_cnt; // stream bits taken so far
    logic own_done; // own frames complete
    logic done; // done output
    logic low_during_cfg; // low-during-configuration output
    logic core_bit; // bit for the internal configuration logic
    logic core_stb;
    logic ready; // ready/busy output
    logic [BM_W-1:0] busy_age; // cycles since the last byte arrived
  } st_t;

  st_t s_reg;
  st_t s_next;
  logic rise_ev; // timing generator says: rising edge now
  logic fall_ev; // timing generator says: falling edge now
  logic have; // a bit is produced at this rise
  logic b; // that bit
  logic fwd; // that bit is forwarded downstream

  byte_xfer_if xfer ();

  // bus-domain capture of peripheral writes
  periph_capture u_cap (
    .bus_clk(BUS_CLK),
    .arst_n(ARST_N),
    .chip_sel_a_n(CHIP_SEL_A_N),
    .chip_sel_b_n(CHIP_SEL_B_N),
    .chip_sel_c(CHIP_SEL_C),
    .write_strobe_n(WRITE_STROBE_N),
    .data_in(DATA_IN),
    .xfer(xfer)
  );

  assign rise_ev = (s_reg.phase == '0);
  assign fall_ev = (s_reg.phase == PH_W'(HALF));

  // all next-state logic of the timing domain
  always_comb begin
    s_next = s_reg;
    have = 1'b0;
    b = 1'b0;
    fwd = 1'b0;
    s_next.core_stb = 1'b0;
    // pin synchronisers
    s_next.rst_s1 = CFG_RESET_N;
    s_next.rst_s2 = s_reg.rst_s1;
    s_next.mode_s1 = MODE;
    s_next.mode_s2 = s_reg.mode_s1;
    s_next.early_s1 = EARLY_DONE;
    s_next.early_s2 = s_reg.early_s1;
    s_next.down_s1 = ADDR_DOWN;
    s_next.down_s2 = s_reg.down_s1;
    s_next.din_s1 = SER_DIN;
    s_next.din_s2 = s_reg.din_s1;
    s_next.dat_s1 = DATA_IN;
    s_next.dat_s2 = s_reg.dat_s1;
    // the write event reaches the buffer only after two flops
    s_next.tog_s1 = xfer.tog;
    s_next.tog_s2 = s_reg.tog_s1;
    s_next.tog_s3 = s_reg.tog_s2;
    // timing generator never stops, so write latency depends on phase
    if (s_reg.phase == PH_W'(CFG_DIV - 1)) begin
      s_next.phase = '0;
    end else begin
      s_next.phase = s_reg.phase + PH_W'(1);
    end
    case (s_reg.state)
      ST_IDLE: begin
        // clock rests high; start only once the reset pin is released
        s_next.cfg_clk = 1'b1;
        if (s_reg.rst_s2) begin
          s_next.state = ST_LOAD;
          s_next.mode = s_reg.mode_s2;
          s_next.early = s_reg.early_s2;
          s_next.down = s_reg.down_s2;
          s_next.addr = ADDR_W'(cfg_loader_pkg::ADDR_START);
          s_next.bit_idx = '0;
          s_next.bit_cnt = '0;
          s_next.left = '0;
          s_next.parked = 1'b0;
          s_next.d1 = 1'b1;
          s_next.d2 = 1'b1;
          s_next.f1 = 1'b0;
          s_next.f2 = 1'b0;
        end
      end
      ST_LOAD: begin
        if (!s_reg.rst_s2) begin
          // reset pin pulled low again: abandon this load, clock at rest
          s_next.state = ST_IDLE;
          s_next.cfg_clk = 1'b1;
        end else if (rise_ev && !s_reg.cfg_clk) begin
          // produce the bit for this rising edge
          case (s_reg.mode)
            cfg_loader_pkg::MODE_MSER: begin
              // memory moved at the last rise, its bit is valid now
              have = 1'b1;
              b = s_reg.din_s2;
            end
            cfg_loader_pkg::MODE_MPAR: begin
              have = 1'b1;
              if (s_reg.bit_idx == 3'h0) begin
                // take the byte, then move the address, same edge
                s_next.pbyte = s_reg.dat_s2;
                b = s_reg.dat_s2[0];
                if (s_reg.down) begin
                  s_next.addr = s_reg.addr - ADDR_W'(1);
                end else begin
                  s_next.addr = s_reg.addr + ADDR_W'(1);
                end
              end else begin
                b = s_reg.pbyte[s_reg.bit_idx];
              end
              // one address step per eight clocks
              s_next.bit_idx = s_reg.bit_idx + 3'h1;
            end
            cfg_loader_pkg::MODE_PERIPH: begin
              if (s_reg.left != 4'h0) begin
                have = 1'b1;
                b = s_reg.shift[0];
                s_next.shift = {1'b0, s_reg.shift[7:1]};
                s_next.left = s_reg.left - 4'h1;
              end else if (s_reg.buf_full) begin
                // second level empty: move the buffered byte down
                have = 1'b1;
                b = s_reg.buf_byte[0];
                s_next.shift = {1'b0, s_reg.buf_byte[7:1]};
                s_next.left = 4'(cfg_loader_pkg::BURST_LEN - 1);
                s_next.buf_full = 1'b0;
              end
            end
            default: begin
              have = 1'b0;
            end
          endcase
          if (have) begin
            s_next.cfg_clk = 1'b1;
            fwd = (s_reg.bit_cnt < CNT_W'(PREAMBLE_BITS)) ||
                  (s_reg.bit_cnt >= CNT_W'(OWN_END));
            // two rises of pipeline plus the half period to the fall
            s_next.d1 = b;
            s_next.f1 = fwd;
            s_next.d2 = s_reg.d1;
            s_next.f2 = s_reg.f1;
            if (s_reg.bit_cnt != '1) begin
              s_next.bit_cnt = s_reg.bit_cnt + CNT_W'(1);
            end
            if (!fwd) begin
              s_next.core_bit = b;
              s_next.core_stb = 1'b1;
            end
            if (s_reg.bit_cnt == CNT_W'(OWN_END - 1)) begin
              s_next.own_done = 1'b1;
              // low-during-config becomes a plain high output for good
              s_next.low_during_cfg = 1'b1;
              if (s_reg.early) begin
                s_next.done = 1'b1;
              end
            end
            // late done comes one clock after the last own bit
            if (s_reg.own_done) begin
              s_next.done = 1'b1;
            end
          end
        end else if (fall_ev && s_reg.cfg_clk) begin
          if (s_reg.mode == cfg_loader_pkg::MODE_PERIPH &&
              s_reg.left <= 4'h1 && !s_reg.buf_full) begin
            // no byte waiting: hold the clock high, show bit 6
            s_next.parked = 1'b1;
            if (s_reg.left == 4'h1) begin
              s_next.dout = s_reg.f1 ? s_reg.d1 : 1'b1;
            end
          end else begin
            s_next.parked = 1'b0;
            s_next.cfg_clk = 1'b0;
            // own frames keep the output high for the chain
            s_next.dout = s_reg.f2 ? s_reg.d2 : 1'b1;
          end
        end
      end
      default: begin
        s_next.state = ST_IDLE;
      end
    endcase
    // a new byte is set after any clear, so it is never lost
    if (s_reg.tog_s2 != s_reg.tog_s3) begin
      s_next.buf_byte = xfer.data;
      s_next.buf_full = 1'b1;
      s_next.busy_age = '0;
    end else if (s_reg.busy_age != BM_W'(BUSY_MIN)) begin
      s_next.busy_age = s_reg.busy_age + BM_W'(1);
    end
    // busy while the first-level buffer holds a byte, and never shorter
    // than the minimum, so a fast transfer still shows a busy pulse
    s_next.ready = !s_next.buf_full &&
                   (s_next.busy_age == BM_W'(BUSY_MIN));
  end

  // state register of the timing domain
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      s_reg <= '0;
      s_reg.state <= ST_IDLE;
      s_reg.cfg_clk <= 1'b1;
      s_reg.dout <= 1'b1;
      s_reg.ready <= 1'b1;
      s_reg.busy_age <= BM_W'(BUSY_MIN);
    end else begin
      s_reg <= s_next;
    end
  end

  assign CFG_CLK = s_reg.cfg_clk;
  assign DOUT = s_reg.dout;
  assign ADDR = s_reg.addr;
  assign READY_BUSY = s_reg.ready;
  assign LOW_DURING_CFG = s_reg.low_during_cfg;
  assign DONE = s_reg.done;
  assign CORE_BIT = s_reg.core_bit;
  assign CORE_BIT_STB = s_reg.core_stb;

  // helper: rises since the last address step
  logic [3:0] rises_reg;
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rises_reg <= 4'h0;
    end else if ($changed(s_reg.addr)) begin
      rises_reg <= 4'h1;
    end else if (s_reg.cfg_clk && !$past(s_reg.cfg_clk)) begin
      rises_reg <= rises_reg + 4'h1;
    end
  end

  // serial output moves only with a falling clock, or when parking
  property p_dout_on_fall;
    @(posedge REF_CLK) disable iff (!ARST_N)
      $changed(DOUT) |-> ($fell(CFG_CLK) || s_reg.parked);
  endproperty
  a_dout_on_fall: assert property (p_dout_on_fall)
    else $error("serial output changed away from a falling edge");

  // a serial bit taken at a rise is the pin level two flops earlier
  property p_ser_sample;
    @(posedge REF_CLK) disable iff (!ARST_N)
      (s_reg.mode == cfg_loader_pkg::MODE_MSER && $rose(CFG_CLK) &&
       $past(s_reg.state) == ST_LOAD) |-> s_reg.d1 == $past(s_reg.din_s2);
  endproperty
  a_ser_sample: assert property (p_ser_sample)
    else $error("serial bit not taken at the rising edge");

  // the address moves only together with a rising clock
  property p_addr_on_rise;
    @(posedge REF_CLK) disable iff (!ARST_N)
      ($changed(ADDR) && s_reg.state == ST_LOAD) |-> $rose(CFG_CLK);
  endproperty
  a_addr_on_rise: assert property (p_addr_on_rise)
    else $error("address stepped without a rising clock");

  // eight clocks separate two address steps
  property p_addr_rate;
    @(posedge REF_CLK) disable iff (!ARST_N)
      ($changed(ADDR) && s_reg.state == ST_LOAD &&
       $past(s_reg.bit_cnt) != '0) |-> $past(rises_reg) == 4'h8;
  endproperty
  a_addr_rate: assert property (p_addr_rate)
    else $error("address step rate is not one per eight clocks");

  // first bit of a latched byte is its D0
  property p_lsb_first;
    @(posedge REF_CLK) disable iff (!ARST_N)
      ($changed(ADDR) && s_reg.state == ST_LOAD) |->
        s_reg.d1 == s_reg.pbyte[0];
  endproperty
  a_lsb_first: assert property (p_lsb_first)
    else $error("byte not sent least significant bit first");

  // once high, low-during-config stays high
  property p_ldc_sticky;
    @(posedge REF_CLK) disable iff (!ARST_N)
      $past(LOW_DURING_CFG) |-> LOW_DURING_CFG;
  endproperty
  a_ldc_sticky: assert property (p_ldc_sticky)
    else $error("low-during-config output fell after configuration");

  // early done rises with the last own bit's clock edge
  property p_early_done;
    @(posedge REF_CLK) disable iff (!ARST_N)
      ($rose(s_reg.own_done) && s_reg.early) |-> DONE && $rose(CFG_CLK);
  endproperty
  a_early_done: assert property (p_early_done)
    else $error("early done not raised with the last own bit");

  // a synchronised byte arrival makes the handshake busy next cycle
  property p_busy_on_byte;
    @(posedge REF_CLK) disable iff (!ARST_N)
      (s_reg.tog_s2 != s_reg.tog_s3) |=> !READY_BUSY;
  endproperty
  a_busy_on_byte: assert property (p_busy_on_byte)
    else $error("ready/busy did not go busy on a received byte");

  // the buffer fills only after the two-flop crossing
  property p_buf_after_sync;
    @(posedge REF_CLK) disable iff (!ARST_N)
      $rose(s_reg.buf_full) |-> $past(s_reg.tog_s2 != s_reg.tog_s3);
  endproperty
  a_buf_after_sync: assert property (p_buf_after_sync)
    else $error("buffer filled without a synchronised write event");

  // parked clock stays high, nothing is started while reset pin is low
  property p_park_high;
    @(posedge REF_CLK) disable iff (!ARST_N)
      (s_reg.parked || (s_reg.state == ST_IDLE)) |-> CFG_CLK;
  endproperty
  a_park_high: assert property (p_park_high)
    else $error("configuration clock not held high while parked");
endmodule

// ---- cfg_loader_pkg.sv ----
/*
  constants shared by the configuration loader and its self-checking bench.
  assumes a 100 MHz timing-generator clock and a byte-wide data path.
*/
package cfg_loader_pkg;
  // timing generator reference period and configuration clock period
  localparam int REF_PERIOD_NS = 10;
  localparam int CFG_PERIOD_NS = 1000;
  // reference cycles per configuration clock period
  localparam int CFG_DIV = CFG_PERIOD_NS / REF_PERIOD_NS;
  // slowest byte-wide memory that parallel mode must tolerate
  localparam int MEM_ACCESS_NS = 4000;
  // bits per byte and configuration clocks per byte
  localparam int BITS_PER_BYTE = 8;
  localparam int BURST_LEN = 8;
  // bit shown on the serial output while the clock is parked
  localparam int PARK_BIT = 6;
  // stream layout: forwarded header, then own frames, then overflow
  localparam int PREAMBLE_BITS = 40;
  localparam int OWN_BITS = 1024;
  // memory address bus
  localparam int ADDR_W = 16;
  localparam logic [15:0] ADDR_START = 16'h0000;
  // mode pin encodings
  localparam logic [1:0] MODE_MSER = 2'h0;
  localparam logic [1:0] MODE_MPAR = 2'h1;
  localparam logic [1:0] MODE_PERIPH = 2'h2;
endpackage

// ---- byte_xfer_if.sv ----
/*
  carries one received byte from the processor bus domain to the
  timing-generator domain as a toggle event with stable data.
  assumes data is written one cycle before the toggle flips.
*/
interface byte_xfer_if;
  logic tog; // flips once per captured byte
  logic [7:0] data; // byte, stable until the next write
  modport src (output tog, output data);
  modport dst (input tog, input data);
endinterface

// ---- periph_capture.sv ----
/*
  processor bus capture stage, clocked by the processor bus clock.
  assumes the select and strobe pins are asynchronous to every clock.
*/
module periph_capture (
  input wire logic bus_clk,
  input wire logic arst_n,
  input wire logic chip_sel_a_n,
  input wire logic chip_sel_b_n,
  input wire logic chip_sel_c,
  input wire logic write_strobe_n,
  input wire logic [7:0] data_in,
  byte_xfer_if.src xfer
);
  typedef struct packed {
    logic cond_s1; // first sync stage, read only by cond_s2
    logic cond_s2; // synchronised write condition
    logic cond_s3; // previous value for edge detection
    logic [7:0] dat_s1; // first data sync stage
    logic [7:0] dat_s2; // synchronised data
    logic [7:0] hold; // data seen while the condition was true
    logic [7:0] data; // byte handed over
    logic pend; // toggle is due next cycle
    logic tog; // event toggle
  } cap_t;

  cap_t s_reg;
  cap_t s_next;
  logic cond; // all three selects and the strobe asserted

  assign cond = !chip_sel_a_n && !chip_sel_b_n && chip_sel_c &&
                !write_strobe_n;

  // capture on the trailing edge of the combined condition
  always_comb begin
    s_next = s_reg;
    s_next.cond_s1 = cond;
    s_next.cond_s2 = s_reg.cond_s1;
    s_next.cond_s3 = s_reg.cond_s2;
    s_next.dat_s1 = data_in;
    s_next.dat_s2 = s_reg.dat_s1;
    s_next.pend = 1'b0;
    // data need not hold past the strobe, so keep what was seen inside
    if (s_reg.cond_s2) begin
      s_next.hold = s_reg.dat_s2;
    end
    if (s_reg.cond_s3 && !s_reg.cond_s2) begin
      s_next.data = s_reg.hold;
      s_next.pend = 1'b1;
    end
    // toggle a cycle after the data so the far side never sees it move
    if (s_reg.pend) begin
      s_next.tog = !s_reg.tog;
    end
  end

  // state register
  always_ff @(posedge bus_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign xfer.tog = s_reg.tog;
  assign xfer.data = s_reg.data;

  // a completed write always produces exactly one handover event
  property p_capture_toggle;
    @(posedge bus_clk) disable iff (!arst_n)
      (s_reg.cond_s3 && !s_reg.cond_s2) |=> ##1 $changed(s_reg.tog);
  endproperty
  a_capture_toggle: assert property (p_capture_toggle)
    else $error("write capture did not raise a handover event");
endmodule

// ---- cfg_mem_model.sv ----
/*
  far-side model: a serial memory and a slow byte-wide memory.
  assumes the loader drives the clock and the address; a high enable
  rewinds the serial memory to its first bit.
*/
module cfg_mem_model #(
  parameter logic [31:0] STREAM = 32'hA5C3_96E1
) (
  input wire logic cfg_clk,
  input wire logic ce_n,
  input wire logic [15:0] addr,
  output logic ser_o,
  output logic [7:0] byte_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int bit_addr = 0; // serial memory bit address
  logic [15:0] a_seen; // address under lookup
  // each rising clock steps the bit address
  always @(posedge cfg_clk or posedge ce_n) begin
    if (ce_n === 1'b1) begin
      bit_addr <= 0;
    end else begin
      bit_addr <= bit_addr + 1;
    end
  end
  // a released line shows the inverse of the last bit, never a held value
  assign ser_o = ce_n ? ~STREAM[(bit_addr + 31) % 32] : STREAM[bit_addr % 32];
  initial byte_o = 8'h5A;
  // slow access: junk until 4100 ns after the address settles
  always @(addr) begin
    a_seen = addr;
    byte_o = ~byte_o;
    #4100;
    if (addr == a_seen) byte_o = 8'h5A ^ addr[7:0];
  end
endmodule

// ---- config_bitstream_loader_bench.sv ----
/*
  self-checking bench for the loader in its three loading modes.
  assumes cfg_mem_model stands for the memories; the bench is the processor.
*/
module config_bitstream_loader_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DIV = 52; // shortest divider that keeps 8 periods > 4000 ns
  localparam logic [31:0] STREAM = 32'hA5C3_96E1;
  logic ref_clk, bus_clk, arst_n, cfg_reset_n, addr_down, early_done;
  logic cs_a_n, cs_b_n, cs_c, ws_n, ser, cfg_clk, dout, rdy, low_during_cfg, done;
  logic core_bit, core_stb;
  logic [1:0] mode;
  logic [7:0] bus_data, mem_byte, data_pin;
  logic [15:0] addr;
  logic cap[$]; // output seen at each clock rise
  logic core_q[$]; // own bits handed inward
  int error_cnt = 0;
  int checked = 0;
  // bus data in peripheral mode, memory data otherwise
  assign data_pin = (mode == cfg_loader_pkg::MODE_PERIPH) ? bus_data : mem_byte;
  config_bitstream_loader #(.CFG_DIV(DIV), .PREAMBLE_BITS(8), .OWN_BITS(16))
  i_config_bitstream_loader (.REF_CLK(ref_clk), .ARST_N(arst_n),
    .BUS_CLK(bus_clk), .CFG_RESET_N(cfg_reset_n), .MODE(mode),
    .EARLY_DONE(early_done), .ADDR_DOWN(addr_down), .SER_DIN(ser),
    .DATA_IN(data_pin), .CHIP_SEL_A_N(cs_a_n), .CHIP_SEL_B_N(cs_b_n),
    .CHIP_SEL_C(cs_c), .WRITE_STROBE_N(ws_n), .CFG_CLK(cfg_clk),
    .DOUT(dout), .ADDR(addr), .READY_BUSY(rdy), .LOW_DURING_CFG(low_during_cfg),
    .DONE(done), .CORE_BIT(core_bit), .CORE_BIT_STB(core_stb));
  cfg_mem_model #(.STREAM(STREAM)) i_cfg_mem_model (.cfg_clk(cfg_clk),
    .ce_n(!cfg_reset_n), .addr(addr), .ser_o(ser), .byte_o(mem_byte));
  // next chain device takes the output on each rise
  always @(posedge cfg_clk) cap.push_back(dout);
  always @(posedge ref_clk) if (core_stb === 1'b1) core_q.push_back(core_bit);
  // raw stream bit k; parallel bytes go LSB first
  function automatic logic sb(input bit par, input int k);
    logic [7:0] b;
    b = 8'h5A ^ 8'(k / 8);
    return par ? b[k % 8] : STREAM[k % 32];
  endfunction
  // output expected: own frames show high
  function automatic logic de(input bit par, input int k);
    return (k >= 8 && k < 24) ? 1'b1 : sb(par, k);
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // reset, check idle outputs, hold off start past the memory access
  task automatic rst(input logic [1:0] m, input logic dn, input logic ed);
    @(posedge ref_clk);
    arst_n <= 1'b0;
    cfg_reset_n <= 1'b0;
    mode <= m;
    addr_down <= dn;
    early_done <= ed;
    repeat (6) @(posedge ref_clk);
    arst_n <= 1'b1;
    @(posedge ref_clk);
    cap.delete();
    core_q.delete();
    chk({cfg_clk, dout, rdy, low_during_cfg, done}, 16'h1C);
    chk(addr, 16'h0000);
    repeat (500) @(posedge ref_clk);
    chk(16'(cap.size()), 16'h0000);
    cfg_reset_n <= 1'b1;
  endtask
  // judge forwarded and inward bits once enough rises are seen
  task automatic judge(input bit par);
    int o, k, bad, best, n;
    best = 0;
    n = 0;
    while (cap.size() < 36 && n < 4000) begin
      @(posedge ref_clk);
      n++;
    end
    for (o = 6; o >= 0; o--) begin
      bad = 0;
      for (k = 0; k < 28; k++) if (cap[o+k] !== de(par, k)) bad++;
      if (bad == 0) best = o;
    end
    for (k = 0; k < 28; k++) chk(16'(cap[best+k]), 16'(de(par, k)));
    chk(16'(core_q.size()), 16'h0010);
    for (k = 0; k < 16; k++) chk(16'(core_q[k]), 16'(sb(par, k + 8)));
    chk({done, low_during_cfg}, 16'h0003);
  endtask
  task automatic serial_run();
    rst(cfg_loader_pkg::MODE_MSER, 1'b0, 1'b0);
    judge(1'b0);
  endtask
  // address steps every 8 clock periods, then the byte stream is judged
  task automatic parallel_run();
    int n;
    longint t;
    logic [15:0] a0;
    rst(cfg_loader_pkg::MODE_MPAR, 1'b0, 1'b1);
    n = 0;
    while (addr === 16'h0000 && n < 2000) begin
      @(posedge ref_clk);
      n++;
    end
    // both steps are seen with the same one-edge lag, so the span is exact
    t = $time;
    a0 = addr;
    n = 0;
    while (addr === a0 && n < 2000) begin
      @(posedge ref_clk);
      n++;
    end
    chk(16'(($time - t) / 10), 16'(8 * DIV));
    judge(1'b1);
  endtask
  task automatic down_run();
    rst(cfg_loader_pkg::MODE_MPAR, 1'b1, 1'b0);
    repeat (DIV * 3) @(posedge ref_clk);
    chk(addr, 16'hFFFF);
  endtask
  // one processor write; waits for busy and its end
  task automatic wr(input logic [7:0] b);
    int n;
    @(posedge bus_clk);
    cs_a_n <= 1'b0;
    cs_b_n <= 1'b0;
    cs_c <= 1'b1;
    ws_n <= 1'b0;
    bus_data <= b;
    repeat (20) @(posedge bus_clk);
    ws_n <= 1'b1;
    cs_a_n <= 1'b1;
    cs_b_n <= 1'b1;
    cs_c <= 1'b0;
    n = 0;
    while (rdy !== 1'b0 && n < 100) begin
      @(posedge ref_clk);
      n++;
    end
    chk(16'(rdy), 16'h0000);
    n = 0;
    while (rdy !== 1'b1 && n < 2000) begin
      @(posedge ref_clk);
      n++;
    end
    chk(16'(2 * n >= 5 * DIV && n <= 9 * DIV), 16'h0001);
  endtask
  task automatic periph_run();
    rst(cfg_loader_pkg::MODE_PERIPH, 1'b0, 1'b0);
    wr(8'h2D);
    repeat (12 * DIV) @(posedge ref_clk);
    chk({cfg_clk, dout}, 16'h0002);
    wr(8'hF0);
    wr(8'h0F);
    wr(8'h3C);
    repeat (12 * DIV) @(posedge ref_clk);
    chk({cfg_clk, dout, done, low_during_cfg}, 16'h000B);
    chk(16'(cap.size()), 16'd31);
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    bus_clk = 1'b0;
    #1.7;
    forever #3 bus_clk = ~bus_clk;
  end
  initial begin
    #400us;
    error_cnt++;
    close_out();
  end
  initial begin
    arst_n = 1'b0;
    cfg_reset_n = 1'b0;
    mode = 2'h0;
    addr_down = 1'b0;
    early_done = 1'b0;
    cs_a_n = 1'b1;
    cs_b_n = 1'b1;
    cs_c = 1'b0;
    ws_n = 1'b1;
    bus_data = 8'h00;
    serial_run();
    parallel_run();
    down_run();
    periph_run();
    close_out();
  end
endmodule
